//--- verilog/sac_pkg.sv
// Constants shared by the converter control block and its result FIFO.
// Assumes a single 250 MHz system clock drives every process.
package sac_pkg;

    // Result width and FIFO shape
    localparam int RES_W       = 12;
    localparam int FIFO_DEPTH  = 8;

    // System clock and conversion clock limit, in kHz
    localparam int SYS_CLK_KHZ  = 250000;
    localparam int CONV_MAX_KHZ = 14000;
    // Least divide ratio that keeps the step rate at or below the limit
    localparam int CONV_DIV = (SYS_CLK_KHZ + CONV_MAX_KHZ - 1) / CONV_MAX_KHZ;
    localparam int DIV_W    = 5;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);

    // Power-up wait, least time, rounded up to whole cycles
    localparam int PWR_WAIT_NS = 10000;
    localparam int SYS_PER_NS  = 4;
    localparam int PWR_CYC = (PWR_WAIT_NS + SYS_PER_NS - 1) / SYS_PER_NS;
    localparam int PWR_W   = 12;
    localparam logic [PWR_W-1:0] PWR_LAST = PWR_W'(PWR_CYC - 1);

    // Acquisition time in conversion-clock steps
    localparam int SMP_W = 3;
    localparam logic [SMP_W-1:0] SMP_LAST = 3'h3;

    // Bit index of the first and last decided bit
    localparam int BIT_W = 4;
    localparam logic [BIT_W-1:0] BIT_MSB = 4'hB;
    localparam logic [BIT_W-1:0] BIT_LSB = 4'h0;

    // Control states, one-hot
    typedef enum logic [4:0] {
        ST_OFF    = 5'h01,
        ST_IDLE   = 5'h02,
        ST_SAMPLE = 5'h04,
        ST_CONV   = 5'h08,
        ST_STORE  = 5'h10
    } sac_state_t;

endpackage

//--- verilog/sac_fifo.sv
// Result FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module sac_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic [WIDTH-1:0]      o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q, wr_ptr_d;
    logic [AW-1:0]    rd_ptr_q, rd_ptr_d;
    logic [AW:0]      count_q, count_d;
    logic             push, pop;

    // Handshakes and flags
    assign o_in_ready  = (count_q != (AW+1)'(DEPTH));
    assign o_out_valid = (count_q != '0);
    assign o_out_data  = mem_q[rd_ptr_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // Pointer and count next values
    always_comb
    begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d  = count_q;
        if (push)
        begin
            wr_ptr_d = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
        end
        if (pop)
        begin
            rd_ptr_d = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
        end
        if (push && !pop)
        begin
            count_d = count_q + 1'b1;
        end
        else if (pop && !push)
        begin
            count_d = count_q - 1'b1;
        end
    end

    // Pointer registers
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge i_sys_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

endmodule // sac_fifo

//--- verilog/sac_ctrl.sv
// Conversion control for a 12-bit successive-approximation converter.
// Assumes the comparator output and the frame start pin are asynchronous;
// start, mode, power and read strobes come from logic on i_sys_clk.
`timescale 1ns/1ns

// Summary of operation
// - Binary search against the DAC, one bit per step, MSB first.
// - Twelve-bit results; timing supports up to 700 ksps.
// - Step rate divided down to at most 14 MHz.
// - Start bit or frame start trigger begins a conversion.
// - Continuous mode runs fine with the frame start trigger idle.
// - No conversion until 10 us after power-up or wake.
// - Completion sets a status bit and raises frame end.
// - Frame end stays high until CPU or DMA reads the result.
// - Frame end is a plain level usable for interrupt or DMA request.
// - Single-shot bit picks one conversion per trigger or continuous.
// - Continuous results queue for DMA transfer one by one.
module sac_ctrl
    import sac_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_pwr_en,
    input  wire logic                 i_start,
    input  wire logic                 i_sof,
    input  wire logic                 i_one_shot,
    input  wire logic                 i_cmp,
    input  wire logic                 i_res_rd,
    input  wire logic                 i_stat_clr,
    output logic [sac_pkg::RES_W-1:0] o_dac_code,
    output logic                      o_sample,
    output logic                      o_ready,
    output logic                      o_busy,
    output logic                      o_done,
    output logic                      o_eof,
    output logic [sac_pkg::RES_W-1:0] o_res_data
);
    import sac_pkg::*;

    sac_state_t       st_q, st_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [PWR_W-1:0] pwr_q, pwr_d;
    logic [SMP_W-1:0] smp_q, smp_d;
    logic [BIT_W-1:0] bit_q, bit_d;
    logic [RES_W-1:0] sar_q, sar_d;
    logic [RES_W-1:0] dac_q, dac_d;
    logic             run_q, run_d;
    logic             done_q, done_d;
    logic             eof_q, eof_d;
    logic [RES_W-1:0] res_q, res_d;
    logic             smp_o_q, smp_o_d;
    logic             ready_q, ready_d;
    logic             busy_q, busy_d;
    logic             sof_m_q, sof_s_q, sof_p_q;
    logic             cmp_m_q, cmp_s_q;
    logic             tick, sof_rise, req, stored;
    logic             f_in_ready, f_out_valid, f_pop;
    logic [RES_W-1:0] f_out_data;

    // One-hot bit mask for a bit index
    function automatic logic [RES_W-1:0] bit_mask(input logic [BIT_W-1:0] idx);
        bit_mask = RES_W'(1) << idx;
    endfunction

    // Two-stage synchronisers for the pin and comparator
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            sof_m_q <= 1'b0;
            sof_s_q <= 1'b0;
            sof_p_q <= 1'b0;
            cmp_m_q <= 1'b0;
            cmp_s_q <= 1'b0;
        end
        else
        begin
            sof_m_q <= i_sof;
            sof_s_q <= sof_m_q;
            sof_p_q <= sof_s_q;
            cmp_m_q <= i_cmp;
            cmp_s_q <= cmp_m_q;
        end
    end

    assign sof_rise = sof_s_q && !sof_p_q;
    assign req      = i_start || sof_rise;
    assign tick     = (div_q == DIV_LAST);
    assign stored   = (st_q == ST_STORE) && f_in_ready;

    // Sequencer next state
    always_comb
    begin
        st_d    = st_q;
        div_d   = tick ? '0 : div_q + 1'b1;
        pwr_d   = pwr_q;
        smp_d   = smp_q;
        bit_d   = bit_q;
        sar_d   = sar_q;
        dac_d   = dac_q;
        run_d   = run_q;
        smp_o_d = 1'b0;
        case (st_q)
            ST_OFF:
            begin
                if (pwr_q == PWR_LAST)
                begin
                    st_d = ST_IDLE;
                end
                else
                begin
                    pwr_d = pwr_q + 1'b1;
                end
            end
            ST_IDLE:
            begin
                if (req || (run_q && !i_one_shot))
                begin
                    st_d    = ST_SAMPLE;
                    div_d   = '0;
                    smp_d   = '0;
                    run_d   = !i_one_shot;
                    smp_o_d = 1'b1; // Sample switch closes with the state
                end
            end
            ST_SAMPLE:
            begin
                smp_o_d = 1'b1;
                if (tick)
                begin
                    if (smp_q == SMP_LAST)
                    begin
                        st_d    = ST_CONV;
                        smp_o_d = 1'b0;
                        bit_d   = BIT_MSB;
                        sar_d   = '0;
                        dac_d   = bit_mask(BIT_MSB);
                    end
                    else
                    begin
                        smp_d = smp_q + 1'b1;
                    end
                end
            end
            ST_CONV:
            begin
                // keep or drop trial bit, twelve steps
                if (tick)
                begin
                    sar_d = cmp_s_q ? dac_q : (dac_q & ~bit_mask(bit_q));
                    if (bit_q == BIT_LSB)
                    begin
                        st_d = ST_STORE;
                        dac_d = sar_d;
                    end
                    else
                    begin
                        bit_d = bit_q - 1'b1;
                        dac_d = sar_d | bit_mask(bit_q - 1'b1);
                    end
                end
            end
            ST_STORE:
            begin
                // continue once the queue takes the word
                if (f_in_ready)
                begin
                    st_d  = ST_IDLE;
                    run_d = run_q && !i_one_shot;
                end
            end
            default:
            begin
                st_d = ST_OFF;
            end
        endcase
        if (!i_pwr_en)
        begin
            st_d  = ST_OFF;
            pwr_d = '0;
            run_d   = 1'b0;
            smp_o_d = 1'b0; // Never sample while powered down
        end
        // Registered status decodes of the next state
        ready_d = (st_d != ST_OFF);
        busy_d  = (st_d != ST_OFF) && (st_d != ST_IDLE);
    end

    // Result hand-off register and flags
    assign f_pop = f_out_valid && (!eof_q || i_res_rd);
    always_comb
    begin
        res_d  = res_q;
        eof_d  = eof_q;
        done_d = done_q;
        // read drops frame end unless another word waits
        if (eof_q && i_res_rd)
        begin
            eof_d = 1'b0;
        end
        if (f_pop)
        begin
            res_d = f_out_data;
            eof_d = 1'b1;
        end
        // status bit, set wins over clear
        if (i_stat_clr || (eof_q && i_res_rd))
        begin
            done_d = 1'b0;
        end
        if (stored)
        begin
            done_d = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            st_q    <= ST_OFF;
            div_q   <= '0;
            pwr_q   <= '0;
            smp_q   <= '0;
            bit_q   <= BIT_MSB;
            sar_q   <= '0;
            dac_q   <= '0;
            run_q   <= 1'b0;
            smp_o_q <= 1'b0;
            res_q   <= '0;
            eof_q   <= 1'b0;
            done_q  <= 1'b0;
            ready_q <= 1'b0;
            busy_q  <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            div_q   <= div_d;
            pwr_q   <= pwr_d;
            smp_q   <= smp_d;
            bit_q   <= bit_d;
            sar_q   <= sar_d;
            dac_q   <= dac_d;
            run_q   <= run_d;
            smp_o_q <= smp_o_d;
            res_q   <= res_d;
            eof_q   <= eof_d;
            done_q  <= done_d;
            ready_q <= ready_d;
            busy_q  <= busy_d;
        end
    end

    // result queue between converter and reader
    sac_fifo #(
        .WIDTH (RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_in_data   (sar_q),
        .i_in_valid  (st_q == ST_STORE),
        .o_in_ready  (f_in_ready),
        .o_out_data  (f_out_data),
        .o_out_valid (f_out_valid),
        .i_out_ready (!eof_q || i_res_rd)
    );

    // Outputs straight from registers
    assign o_dac_code = dac_q;
    assign o_sample   = smp_o_q;
    assign o_ready    = ready_q;
    assign o_busy     = busy_q;
    assign o_eof      = eof_q;
    assign o_done     = done_q;
    assign o_res_data = res_q;

endmodule // sac_ctrl

//--- tb/sac_ctrl_monitor.sv
// Port checker for the conversion control block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module sac_ctrl_chk
    import sac_pkg::*;
(
    input wire logic                      i_sys_clk,
    input wire logic                      i_rst_n,
    input wire logic                      i_pwr_en,
    input wire logic                      i_start,
    input wire logic                      i_res_rd,
    input wire logic [sac_pkg::RES_W-1:0] o_dac_code,
    input wire logic                      o_sample,
    input wire logic                      o_ready,
    input wire logic                      o_busy,
    input wire logic                      o_done,
    input wire logic                      o_eof,
    input wire logic [sac_pkg::RES_W-1:0] o_res_data
);
    logic [11:0] pw_q;
    logic [11:0] pw_d;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Cycles since power and reset were both released
    always_comb
    begin
        pw_d = (pw_q == 12'hFFF) ? pw_q : pw_q + 12'h001;
        if (!i_rst_n || !i_pwr_en)
            pw_d = 12'h000;
    end
    always_ff @(posedge i_sys_clk)
        pw_q <= pw_d;
    chk_ready_early: assert property (o_ready |-> pw_q >= 12'h9C4)
        else $error("ready before wait");
    chk_ready_late: assert property (pw_q == 12'h9CE |-> o_ready)
        else $error("ready late");
    chk_off_idle: assert property (!o_ready |-> !o_busy && !o_sample)
        else $error("busy while not ready");
    chk_start_taken: assert property (
        i_start && o_ready && !o_busy |=> o_sample && o_busy)
        else $error("start dropped");
    chk_sample_len: assert property (
        $rose(o_sample) |-> ##60 o_sample ##[1:16] !o_sample)
        else $error("acquisition length");
    chk_msb_first: assert property (
        $fell(o_sample) && o_busy |-> ##[0:2] o_dac_code == 12'h800)
        else $error("first trial not MSB");
    chk_eof_hold: assert property (
        o_eof && !i_res_rd |=> o_eof && $stable(o_res_data))
        else $error("frame end dropped");
    chk_done_flag: assert property ($rose(o_eof) |-> $past(o_done))
        else $error("status not set");
    chk_eof_after: assert property ($rose(o_done) |-> ##[1:2] o_eof)
        else $error("no frame end");
    chk_sample_busy: assert property (o_sample |-> o_busy)
        else $error("sample while idle");
    cover property ($rose(o_ready));
    cover property (o_eof && i_res_rd);
    cover property ($fell(o_sample) && o_busy);
endmodule // sac_ctrl_chk

bind sac_ctrl sac_ctrl_chk u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_pwr_en(i_pwr_en),
    .i_start(i_start), .i_res_rd(i_res_rd), .o_dac_code(o_dac_code),
    .o_sample(o_sample), .o_ready(o_ready), .o_busy(o_busy),
    .o_done(o_done), .o_eof(o_eof), .o_res_data(o_res_data)
);

//--- tb/sac_reader.sv
// Model of the CPU or DMA reader and of the comparator.
// Assumes the bench samples the word while the read strobe is high.
`timescale 1ns/1ns
module sac_reader
    import sac_pkg::*;
(
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_hold,
    input  wire logic [7:0]                i_dly,
    input  wire logic [sac_pkg::RES_W-1:0] i_vin,
    input  wire logic [sac_pkg::RES_W-1:0] i_dac_code,
    input  wire logic                      i_eof,
    output logic                           o_res_rd,
    output logic                           o_cmp
);
    logic [7:0] wait_q = 8'h00;
    logic       rd_q   = 1'b0;
    // Read strobe from its own register
    assign o_res_rd = rd_q;
    // Keep the bit while the input is not below the trial
    assign o_cmp = (i_vin >= i_dac_code);
    // frame end used as the transfer request, one read per word
    always @(negedge i_sys_clk)
    begin
        if (rd_q)
        begin
            rd_q   <= 1'b0;
            wait_q <= i_dly;
        end
        else if (wait_q != 8'h00)
            wait_q <= wait_q - 8'h01;
        else if (i_eof && !i_hold)
            rd_q <= 1'b1;
    end
endmodule // sac_reader

//--- tb/sac_ctrl_test.sv
// Self-checking bench for the conversion control block.
// Assumes the reader model and the bound checker are compiled first.
`timescale 1ns/1ns
module sac_ctrl_test;
    import sac_pkg::*;
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             pwr = 1'b0;
    logic             start = 1'b0;
    logic             sof = 1'b0;
    logic             one = 1'b1;
    logic             clr = 1'b0;
    logic             hold = 1'b0;
    logic [7:0]       dly = 8'h00;
    logic [RES_W-1:0] vin = 12'h000;
    logic [RES_W-1:0] code, res;
    logic             cmp, rd, smp, rdy, busy, done, eof;
    logic [RES_W-1:0] exp_q[$];
    logic [RES_W-1:0] tbl[4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
    int               err_total = 0;
    int               num_checks = 0;
    int               cyc = 0;

    always #2 clk = ~clk;

    sac_ctrl DUT (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_pwr_en(pwr),
        .i_start(start), .i_sof(sof), .i_one_shot(one), .i_cmp(cmp),
        .i_res_rd(rd), .i_stat_clr(clr), .o_dac_code(code),
        .o_sample(smp), .o_ready(rdy), .o_busy(busy), .o_done(done),
        .o_eof(eof), .o_res_data(res)
    );
    sac_reader u_rdr (
        .i_sys_clk(clk), .i_hold(hold), .i_dly(dly), .i_vin(vin),
        .i_dac_code(code), .i_eof(eof), .o_res_rd(rd), .o_cmp(cmp)
    );

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    // Wait until every expected word is read and the block is idle
    task automatic drain();
        while (exp_q.size() != 0 || busy !== 1'b0)
            @(negedge clk);
        chk(eof === 1'b0, "frame end after read");
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Compare each word as the reader takes it, oldest note first
    always @(negedge clk)
    begin
        #1;
        if (rd === 1'b1 && eof === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(1'b0, "extra result");
            else
                chk(res === exp_q.pop_front(), "result");
        end
    end

    // Cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            chk(1'b0, "timeout");
            complete_run();
        end
    end

    initial
    begin
        void'($urandom(32'hD5B5203C));
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        pwr   = 1'b1;
        repeat (100) @(negedge clk);
        pulse(start);
        repeat (4) @(negedge clk);
        chk(busy === 1'b0, "early start");
        while (rdy !== 1'b1)
            @(negedge clk);
        $display("test power-up done");
        // Single conversions, boundary then random inputs
        for (int i = 0; i < 8; i++)
        begin
            vin = (i < 4) ? tbl[i] : RES_W'($urandom);
            exp_q.push_back(vin);
            pulse(start);
            repeat (40) @(negedge clk);
            pulse(start);
            drain();
        end
        $display("test single done");
        // Sleep and wake again
        pwr = 1'b0;
        repeat (3) @(negedge clk);
        chk(rdy === 1'b0, "ready asleep");
        pwr = 1'b1;
        while (rdy !== 1'b1)
            @(negedge clk);
        // Frame start pin, word held for a stalled reader
        hold = 1'b1;
        vin  = RES_W'($urandom);
        exp_q.push_back(vin);
        sof = 1'b1;
        repeat (8) @(negedge clk);
        sof = 1'b0;
        while (eof !== 1'b1)
            @(negedge clk);
        repeat (20) @(negedge clk);
        chk(done === 1'b1, "status");
        pulse(clr);
        chk(done === 1'b0 && eof === 1'b1, "clear");
        hold = 1'b0;
        drain();
        $display("test frame start done");
        // Continuous run: 1 held + 8 queued + 1 stalled in store
        vin  = RES_W'($urandom);
        hold = 1'b1;
        one  = 1'b0;
        repeat (10) exp_q.push_back(vin);
        pulse(start);
        repeat (3300) @(negedge clk);
        chk(smp === 1'b0 && eof === 1'b1, "stall on full");
        dly  = 8'h40;
        hold = 1'b0;
        one  = 1'b1;
        drain();
        $display("test continuous done");
        complete_run();
    end
endmodule // sac_ctrl_test
